// [src/pss_pkg.sv]
// constants, types and command codes of the pressure sensor host port
// assumes a 40 MHz system clock; the sensor model repeats the command codes as literals

package pss_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned SCL_PERIOD_NS = 2500;
	// longest quarter of a serial clock period, rounded down
	localparam int unsigned QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int unsigned QTR_W         = 5;
	localparam int unsigned CONV_TIME_US  = 10000;
	localparam int unsigned RESET_TIME_US = 3000;
	// least waits, rounded up to whole cycles
	localparam int unsigned CONV_CYC  =
		(CONV_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_CYC =
		(RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TMR_W     = 20;

	// ------------------------------------------------------------------
	// command bytes and fields
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_RESET    = 8'h1E;
	localparam logic [7:0] CMD_ADC_READ = 8'h00;
	localparam logic [7:0] CMD_PROM_RD  = 8'hA0;
	localparam logic [2:0] CONV_GROUP   = 3'h2;   // top three bits 010
	localparam logic [3:0] PROM_GROUP   = 4'hA;   // top nibble 1010
	localparam int unsigned FIELD_LSB   = 1;      // address / ratio field
	localparam int unsigned FIELD_W     = 3;
	localparam logic [1:0] ADC_BYTES    = 2'h3;
	localparam logic [1:0] PROM_BYTES   = 2'h2;

	// ------------------------------------------------------------------
	// two-wire addressing and sequencing
	// ------------------------------------------------------------------
	localparam logic [5:0] I2C_ADDR_BASE  = 6'h3B;   // 111011
	localparam logic       I2C_WRITE      = 1'h0;
	localparam logic       I2C_READ       = 1'h1;
	localparam logic [3:0] ACK_BIT        = 4'h8;
	localparam logic [3:0] LAST_BIT_SPI   = 4'h7;
	localparam logic [3:0] RECOVER_PULSES = 4'h9;
	localparam int unsigned PROM_WORDS    = 8;
	localparam logic [3:0] INIT_RESET     = 4'h1;
	localparam logic [3:0] INIT_PROM0     = 4'h2;
	localparam logic [3:0] INIT_DONE      = 4'hA;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_RECOV = 6'h02,
		S_START = 6'h04,
		S_BYTE  = 6'h08,
		S_STOP  = 6'h10,
		S_DONE  = 6'h20
	} pss_state_e;

	typedef struct packed {
		logic [7:0] cmd;
	} pss_req_s;

	typedef struct packed {
		logic [23:0] data;
		logic        err;
	} pss_rsp_s;

endpackage

// [src/pss_sync.sv]
// two-flop synchroniser for pins that arrive from outside the clock
// assumes the inputs are levels that stay put for several clock cycles
`timescale 1ns/100ps

module pss_sync #(
	parameter int unsigned W = 2
) (
	// clock
	input  wire logic         i_clk_sys,
	// asynchronous levels and their synchronised copies
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	// --------------------------------------------------------------
	// one chain per bit; the first stage feeds only the second
	// --------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic meta_reg;
			logic sync_reg;
			always_ff @(posedge i_clk_sys) begin
				meta_reg <= i_d[g];
				sync_reg <= meta_reg;
			end
			assign o_q[g] = sync_reg;
		end
	endgenerate

endmodule

// [src/pss_host.sv]
// host controller driving the pressure sensor over SPI or two-wire pins
// assumes pull-up on the shared data pin and a 40 MHz system clock
`timescale 1ns/100ps

module pss_host #(
	parameter int unsigned CONV_WAIT  = pss_pkg::CONV_CYC,
	parameter int unsigned RESET_WAIT = pss_pkg::RESET_CYC
) (
	// clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset,
	// straps caught during reset
	input  wire logic              i_i2c_mode,
	input  wire logic              i_select_level,
	// command request and answer
	input  wire logic              i_req_valid,
	input  wire pss_pkg::pss_req_s i_req,
	output logic                   o_req_ready,
	output logic                   o_rsp_valid,
	output pss_pkg::pss_rsp_s      o_rsp,
	// calibration words
	input  wire logic [2:0]        i_cal_idx,
	output logic [15:0]            o_cal_word,
	output logic                   o_cal_done,
	// sensor pins
	output logic                   o_protocol_select_pin,
	output logic                   o_select_pin_n,
	output logic                   o_sclk,
	output logic                   o_sda_o,
	output logic                   o_sda_oe,
	input  wire logic              i_sda_i,
	input  wire logic              i_sdo
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	pss_pkg::pss_state_e state_reg, state_next;
	logic [pss_pkg::QTR_W-1:0] div_reg, div_next;
	logic [1:0]   q_reg, q_next, byte_reg, byte_next, len_reg, len_next;
	logic [1:0]   nread_reg, nread_next;
	logic [3:0]   bit_reg, bit_next, init_reg, init_next;
	logic [7:0]   sh_reg, sh_next, cmd_reg, cmd_next;
	logic [23:0]  res_reg, res_next;
	logic [pss_pkg::TMR_W-1:0] tmr_reg, tmr_next;
	logic [15:0]  cal_reg [pss_pkg::PROM_WORDS], cal_next [pss_pkg::PROM_WORDS];
	logic         mode_reg, sel_reg, wrfrm_reg, wrfrm_next, err_reg, err_next;
	logic         scl_reg, scl_next, sda_reg, sda_next, cs_reg, cs_next;
	logic         ready_reg, ready_next, rspv_reg, rspv_next;
	logic         reset_sent_reg, reset_sent_next;
	pss_pkg::pss_rsp_s rsp_reg, rsp_next;
	logic [15:0]  calw_reg;
	logic         cald_reg, sdao_reg, sdaoe_reg;
	logic [1:0]   pins_s;
	logic         tick, launch, rx_byte, last_byte, din, out_bit;
	logic [3:0]   last_bit;
	logic [7:0]   lcmd;

	// pin inputs pass two flops before use
	pss_sync #(.W(2)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_d       ({i_sda_i, i_sdo}),
		.o_q       (pins_s)
	);

	// --------------------------------------------------------------
	// byte engine helpers
	// --------------------------------------------------------------
	assign tick      = (div_reg == pss_pkg::QTR_W'(pss_pkg::QTR_CYC - 1));
	assign din       = mode_reg ? pins_s[1] : pins_s[0];
	assign last_bit  = mode_reg ? pss_pkg::ACK_BIT : pss_pkg::LAST_BIT_SPI;
	assign rx_byte   = (byte_reg != 2'h0) && !(mode_reg && wrfrm_reg);
	assign last_byte = (byte_reg == len_reg);
	// data released high on two-wire reads; host acks all but the last
	always_comb begin
		if (bit_reg == pss_pkg::ACK_BIT)
			out_bit = rx_byte ? last_byte : 1'b1;
		else if (rx_byte)
			out_bit = mode_reg;
		else
			out_bit = sh_reg[7];
	end

	// --------------------------------------------------------------
	// sequencer next state
	// --------------------------------------------------------------
	always_comb begin
		state_next = state_reg;   div_next   = tick ? '0 : div_reg + 1'b1;
		q_next     = q_reg;       bit_next   = bit_reg;
		byte_next  = byte_reg;    len_next   = len_reg;
		nread_next = nread_reg;   sh_next    = sh_reg;
		cmd_next   = cmd_reg;     res_next   = res_reg;
		err_next   = err_reg;     wrfrm_next = wrfrm_reg;
		scl_next   = scl_reg;     sda_next   = sda_reg;
		cs_next    = cs_reg;      init_next  = init_reg;
		rspv_next  = 1'b0;        rsp_next   = rsp_reg;
		cal_next   = cal_reg;     reset_sent_next = reset_sent_reg;
		tmr_next   = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
		launch     = 1'b0;
		lcmd       = pss_pkg::CMD_ADC_READ;
		unique case (state_reg)
			pss_pkg::S_IDLE: begin
				if (tmr_reg == '0 && init_reg == 4'h0) begin
					// bus recovery first in two-wire mode
					init_next = pss_pkg::INIT_RESET;
					if (mode_reg) begin
						state_next = pss_pkg::S_RECOV;
						bit_next   = 4'h0;
						q_next     = 2'h0;
						div_next   = '0;
					end
				end else if (tmr_reg == '0 && init_reg == pss_pkg::INIT_RESET) begin
					launch = 1'b1;
					lcmd   = pss_pkg::CMD_RESET;
				end else if (tmr_reg == '0 && init_reg != pss_pkg::INIT_DONE) begin
					launch = 1'b1;
					lcmd   = pss_pkg::CMD_PROM_RD
						| {4'h0, init_reg[2:0] - 3'h2, 1'b0};
				end else if (ready_reg && i_req_valid) begin
					launch = 1'b1;
					lcmd   = i_req.cmd;
				end
			end
			pss_pkg::S_RECOV: begin
				sda_next = 1'b1;
				if (tick) begin
					q_next = q_reg + 1'b1;
					if (q_reg == 2'h0) scl_next = 1'b0;
					if (q_reg == 2'h2) scl_next = 1'b1;
					if (q_reg == 2'h3) begin
						bit_next = bit_reg + 1'b1;
						if (bit_reg == pss_pkg::RECOVER_PULSES - 1'b1)
							state_next = pss_pkg::S_IDLE;
					end
				end
			end
			pss_pkg::S_START: begin
				// data falls while the clock is high
				if (tick) begin
					q_next = q_reg + 1'b1;
					if (q_reg == 2'h0) begin
						sda_next = 1'b1;
						scl_next = 1'b1;
					end
					if (q_reg == 2'h1) sda_next = 1'b0;
					if (q_reg == 2'h2) scl_next = 1'b0;
					if (q_reg == 2'h3) state_next = pss_pkg::S_BYTE;
				end
			end
			pss_pkg::S_BYTE: begin
				// mode 0 timing: change while low, sample while high
				if (tick) begin
					q_next = q_reg + 1'b1;
					unique case (q_reg)
						2'h0: sda_next = out_bit;
						2'h1: scl_next = 1'b1;
						2'h2: begin
							// answers arrive most significant bit first
							if (rx_byte && bit_reg != pss_pkg::ACK_BIT)
								sh_next = {sh_reg[6:0], din};
							if (!rx_byte && bit_reg == pss_pkg::ACK_BIT && din)
								err_next = 1'b1;
						end
						2'h3: begin
							scl_next = 1'b0;
							bit_next = bit_reg + 1'b1;
							if (!rx_byte) sh_next = {sh_reg[6:0], 1'b0};
							if (bit_reg == last_bit) begin
								bit_next = 4'h0;
								// result words gather byte by byte
								if (rx_byte) res_next = {res_reg[15:0], sh_reg};
								if (last_byte || err_reg) begin
									state_next = pss_pkg::S_STOP;
								end else begin
									byte_next = byte_reg + 1'b1;
									sh_next   = cmd_reg;
								end
							end
						end
					endcase
				end
			end
			pss_pkg::S_STOP: begin
				if (tick) begin
					q_next = q_reg + 1'b1;
					if (q_reg == 2'h0) begin
						sda_next = 1'b0;
						if (!mode_reg) cs_next = 1'b1;
					end
					// data rises while the clock is high
					if (q_reg == 2'h1 && mode_reg) scl_next = 1'b1;
					if (q_reg == 2'h2 && mode_reg) sda_next = 1'b1;
					if (q_reg == 2'h3) begin
						state_next = pss_pkg::S_DONE;
						// read part is its own transaction
						if (mode_reg && wrfrm_reg && nread_reg != 2'h0 && !err_reg) begin
							state_next = pss_pkg::S_START;
							wrfrm_next = 1'b0;
							len_next   = nread_reg;
							byte_next  = 2'h0;
							sh_next    = {pss_pkg::I2C_ADDR_BASE, ~sel_reg,
								pss_pkg::I2C_READ};
						end
					end
				end
			end
			pss_pkg::S_DONE: begin
				state_next = pss_pkg::S_IDLE;
				rsp_next   = '{data: res_reg, err: err_reg};
				rspv_next  = (init_reg == pss_pkg::INIT_DONE);
				if (init_reg != pss_pkg::INIT_DONE) init_next = init_reg + 1'b1;
				if (init_reg >= pss_pkg::INIT_PROM0 && init_reg != pss_pkg::INIT_DONE)
					cal_next[cmd_reg[pss_pkg::FIELD_LSB +: pss_pkg::FIELD_W]] =
						res_reg[15:0];
				// hold off reads until the conversion is done
				if (cmd_reg[7:5] == pss_pkg::CONV_GROUP)
					tmr_next = pss_pkg::TMR_W'(CONV_WAIT);
				if (cmd_reg == pss_pkg::CMD_RESET) begin
					tmr_next        = pss_pkg::TMR_W'(RESET_WAIT);
					reset_sent_next = 1'b1;
				end
			end
			default: state_next = pss_pkg::S_IDLE;
		endcase
		// answer length follows the command byte
		if (launch) begin
			cmd_next   = lcmd;
			nread_next = (lcmd == pss_pkg::CMD_ADC_READ) ? pss_pkg::ADC_BYTES
				: (lcmd[7:4] == pss_pkg::PROM_GROUP) ? pss_pkg::PROM_BYTES : 2'h0;
			err_next   = 1'b0;
			res_next   = '0;
			byte_next  = 2'h0;
			bit_next   = 4'h0;
			q_next     = 2'h0;
			div_next   = '0;
			if (mode_reg) begin
				// address carries the inverted select level
				state_next = pss_pkg::S_START;
				wrfrm_next = 1'b1;
				len_next   = 2'h1;
				sh_next    = {pss_pkg::I2C_ADDR_BASE, ~sel_reg, pss_pkg::I2C_WRITE};
			end else begin
				// select held low for the whole SPI frame
				state_next = pss_pkg::S_BYTE;
				cs_next    = 1'b0;
				len_next   = nread_next;
				sh_next    = lcmd;
			end
		end
		// no new command while the wait timer runs
		ready_next = (state_next == pss_pkg::S_IDLE) && (tmr_next == '0)
			&& (init_next == pss_pkg::INIT_DONE);
	end

	// --------------------------------------------------------------
	// registers; straps are caught while reset is held
	// --------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_reg <= pss_pkg::S_IDLE;   div_reg   <= '0;
			q_reg     <= 2'h0;              bit_reg   <= 4'h0;
			byte_reg  <= 2'h0;              len_reg   <= 2'h0;
			nread_reg <= 2'h0;              sh_reg    <= 8'h00;
			cmd_reg   <= 8'h00;             res_reg   <= 24'h000000;
			err_reg   <= 1'b0;              wrfrm_reg <= 1'b0;
			tmr_reg   <= '0;                init_reg  <= 4'h0;
			ready_reg <= 1'b0;              rspv_reg  <= 1'b0;
			rsp_reg   <= '0;                reset_sent_reg <= 1'b0;
			cal_reg   <= '{default: 16'h0000};
			calw_reg  <= 16'h0000;
			cald_reg  <= 1'b0;              sdao_reg  <= ~i_i2c_mode;
			sdaoe_reg <= ~i_i2c_mode;
			mode_reg  <= i_i2c_mode;
			sel_reg   <= i_select_level;
			scl_reg   <= i_i2c_mode;
			sda_reg   <= 1'b1;
			cs_reg    <= i_i2c_mode ? i_select_level : 1'b1;
		end else begin
			state_reg <= state_next;        div_reg   <= div_next;
			q_reg     <= q_next;            bit_reg   <= bit_next;
			byte_reg  <= byte_next;         len_reg   <= len_next;
			nread_reg <= nread_next;        sh_reg    <= sh_next;
			cmd_reg   <= cmd_next;          res_reg   <= res_next;
			err_reg   <= err_next;          wrfrm_reg <= wrfrm_next;
			tmr_reg   <= tmr_next;          init_reg  <= init_next;
			ready_reg <= ready_next;        rspv_reg  <= rspv_next;
			rsp_reg   <= rsp_next;          reset_sent_reg <= reset_sent_next;
			cal_reg   <= cal_next;          calw_reg  <= cal_next[i_cal_idx];
			scl_reg   <= scl_next;          sda_reg   <= sda_next;
			cs_reg    <= cs_next;
			cald_reg  <= (init_next == pss_pkg::INIT_DONE);
			// pin drive registered so the pads see no decode glitches
			sdao_reg  <= sda_next & ~mode_reg;
			sdaoe_reg <= ~mode_reg | ~sda_next;
		end
	end

	// outputs straight from flops; two-wire data only ever pulls low
	assign o_req_ready           = ready_reg;
	assign o_rsp_valid           = rspv_reg;
	assign o_rsp                 = rsp_reg;
	assign o_cal_word            = calw_reg;
	assign o_cal_done            = cald_reg;
	assign o_protocol_select_pin = mode_reg;
	assign o_select_pin_n        = cs_reg;
	assign o_sclk                = scl_reg;
	assign o_sda_o               = sdao_reg;
	assign o_sda_oe              = sdaoe_reg;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	a_reset_before_cal: assert property (
		$rose(o_cal_done) |-> reset_sent_reg)
		else $error("calibration finished without reset command");
	a_cs_low_frame: assert property (
		(!mode_reg && state_reg == pss_pkg::S_BYTE) |-> !cs_reg)
		else $error("select high during an SPI byte");
	a_conv_no_overlap: assert property (
		(launch && lcmd[7:5] == pss_pkg::CONV_GROUP) |-> tmr_reg == '0)
		else $error("conversion launched while waiting");
	a_prom_two_bytes: assert property (
		(launch && lcmd[7:4] == pss_pkg::PROM_GROUP)
		|=> nread_reg == pss_pkg::PROM_BYTES)
		else $error("memory read length wrong");
	a_start_only: assert property (
		(mode_reg && $fell(sda_reg) && scl_reg && $past(scl_reg))
		|-> $past(state_reg) == pss_pkg::S_START)
		else $error("data fell under high clock outside start");
	a_adc_three_bytes: assert property (
		(launch && lcmd == pss_pkg::CMD_ADC_READ)
		|=> nread_reg == pss_pkg::ADC_BYTES)
		else $error("result read length wrong");
	a_host_ack_low: assert property (
		(state_reg == pss_pkg::S_BYTE && bit_reg == pss_pkg::ACK_BIT
		&& rx_byte && !last_byte && q_reg == 2'h1) |-> !sda_reg)
		else $error("host did not acknowledge a result byte");
	a_read_after_wait: assert property (
		$rose(rspv_reg) && cmd_reg[7:5] == pss_pkg::CONV_GROUP
		|-> tmr_reg != '0 && !ready_reg)
		else $error("ready raised before conversion time");

	c_cal_done:  cover property ($rose(o_cal_done));
	c_rsp_err:   cover property (rspv_reg && rsp_reg.err);
	c_adc_rsp:   cover property (rspv_reg && cmd_reg == pss_pkg::CMD_ADC_READ);
	c_recover:   cover property (state_reg == pss_pkg::S_RECOV);

endmodule

// [tb/pss_sensor_model.sv]
// behavioural model of the pressure sensor seen from its serial pins
// assumes spi framing from the host; two-wire answers are not modelled,
// so in two-wire mode the sensor stays silent like an absent device
`timescale 1ns/100ps

module pss_sensor_model #(
	parameter int unsigned CONV_NS  = 1000,
	// a bidirectional part would return mid-scale at equal pressures
	parameter logic [23:0] PRES_RAW = 24'hA1B2C3,
	parameter logic [23:0] TEMP_RAW = 24'h5D6E7F
) (
	// pins driven by the host
	input  wire logic i_protocol_select_pin,
	input  wire logic i_select_pin_n,
	input  wire logic i_sclk,
	input  wire logic i_sdi,
	// answer pin
	output logic      o_sdo
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic        loaded   = 1'b0;
	logic        fresh    = 1'b0;
	logic        bad      = 1'b0;
	logic        kind     = 1'b0;
	logic [7:0]  cmd      = 8'h00;
	logic [5:0]  nbits    = 6'h00;
	logic [23:0] out_sr   = 24'h000000;
	realtime     conv_end = 0;

	// eight words, each the repeated address xored onto a fixed base
	function automatic logic [15:0] prom(input logic [2:0] a);
		return 16'h1357 ^ {a, a, a, a, a, 1'b0};
	endfunction

	// ----------------------------------------------------------------
	// command decode, run after the eighth command bit
	// ----------------------------------------------------------------
	task automatic decode();
		out_sr = 24'h000000;
		if (cmd == 8'h1E) begin
			loaded = 1'b1;
			fresh  = 1'b0;
		// conversion start; a start during a running conversion spoils the result
		end else if (cmd[7:5] == 3'h2) begin
			bad      = ($realtime < conv_end);
			kind     = cmd[4];
			fresh    = 1'b1;
			conv_end = $realtime + CONV_NS;
		// result read gives zero when stale or running
		end else if (cmd == 8'h00) begin
			if ($realtime < conv_end) begin
				bad = 1'b1;
			end else if (fresh) begin
				out_sr = (kind ? TEMP_RAW : PRES_RAW) ^ {24{bad}};
				fresh  = 1'b0;
			end
		// memory read returns a sixteen-bit word
		end else if (cmd[7:4] == 4'hA && loaded) begin
			out_sr = {prom(cmd[3:1]), 8'h00};
		end
	endtask

	// ----------------------------------------------------------------
	// serial engine
	// ----------------------------------------------------------------
	initial o_sdo = 1'b0;

	// new frame restarts the bit count
	always @(negedge i_select_pin_n) nbits = 6'h00;

	// spi only with select pin low; sample on rising clock
	always @(posedge i_sclk) begin
		if (!i_select_pin_n && !i_protocol_select_pin && nbits < 8) begin
			cmd   = {cmd[6:0], i_sdi};
			nbits = nbits + 6'h01;
			if (nbits == 8)
				decode();
		end
	end

	// shift out msb first on the falling clock
	always @(negedge i_sclk) begin
		if (!i_select_pin_n && nbits == 8) begin
			o_sdo  = out_sr[23];
			out_sr = out_sr << 1;
		end
	end

	// released line must not keep the last bit
	always @(posedge i_select_pin_n) o_sdo = ~o_sdo;
endmodule

// [tb/tb_top.sv]
// self-checking bench for the sensor host port
// assumes the sensor model above; two-wire case runs with no answerer
`timescale 1ns/100ps

module tb_top;
	localparam logic [23:0] PRES = 24'h3C2B1A;
	localparam logic [23:0] TEMP = 24'h6A5B4C;
	logic              i_clk_sys      = 1'b0;
	logic              i_reset        = 1'b1;
	logic              i_i2c_mode     = 1'b0;
	logic              i_select_level = 1'b1;
	logic              i_req_valid    = 1'b0;
	pss_pkg::pss_req_s i_req          = '0;
	logic [2:0]        i_cal_idx      = 3'h0;
	logic              o_req_ready, o_rsp_valid, o_cal_done, o_sdo;
	pss_pkg::pss_rsp_s o_rsp;
	logic [15:0]       o_cal_word;
	logic              o_protocol_select_pin, o_select_pin_n, o_sclk;
	logic              o_sda_o, o_sda_oe;
	logic [7:0]        addr = 8'h00;
	int                failures = 0, comparisons = 0;
	int                starts = 0, stops = 0, nbit = 0;
	// pull-up on the shared data line
	wire               sda = o_sda_oe ? o_sda_o : 1'b1;

	pss_host #(.CONV_WAIT(50), .RESET_WAIT(40)) pss_host_i (
		.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_i2c_mode(i_i2c_mode),
		.i_select_level(i_select_level), .i_req_valid(i_req_valid),
		.i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
		.o_rsp(o_rsp), .i_cal_idx(i_cal_idx), .o_cal_word(o_cal_word),
		.o_cal_done(o_cal_done),
		.o_protocol_select_pin(o_protocol_select_pin),
		.o_select_pin_n(o_select_pin_n), .o_sclk(o_sclk),
		.o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_sda_i(sda), .i_sdo(o_sdo));

	// conversion shorter than the host wait, as the host assumes
	pss_sensor_model #(.CONV_NS(1000), .PRES_RAW(PRES), .TEMP_RAW(TEMP))
	pss_sensor_model_i (
		.i_protocol_select_pin(o_protocol_select_pin),
		.i_select_pin_n(o_select_pin_n), .i_sclk(o_sclk), .i_sdi(sda),
		.o_sdo(o_sdo));

	// ----------------------------------------------------------------
	// clock, wire monitor and shared tasks
	// ----------------------------------------------------------------
	initial forever #12.5 i_clk_sys = ~i_clk_sys;

	// start and stop are data edges while the clock is high
	always @(negedge sda) if (o_sclk === 1'b1) starts++;
	always @(posedge sda) if (o_sclk === 1'b1) stops++;
	always @(posedge o_sclk) begin
		if (i_i2c_mode && starts > 0 && nbit < 8) begin
			addr = {addr[6:0], sda};
			nbit++;
		end
	end

	function automatic logic [15:0] exp_prom(input logic [2:0] a);
		return 16'h1357 ^ {a, a, a, a, a, 1'b0};
	endfunction

	task automatic check(input string what, input logic [23:0] seen,
			input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic do_reset(input logic mode);
		i_i2c_mode = mode;
		i_reset    = 1'b1;
		repeat (16) @(negedge i_clk_sys);
		i_reset = 1'b0;
	endtask

	// one command: wait ready, strobe one cycle, wait for the answer
	task automatic run_cmd(input logic [7:0] c);
		int n;
		n = 0;
		while (o_req_ready !== 1'b1 && n < 60000) begin
			@(negedge i_clk_sys);
			n++;
		end
		i_req.cmd   = c;
		i_req_valid = 1'b1;
		@(negedge i_clk_sys);
		i_req_valid = 1'b0;
		n = 0;
		while (o_rsp_valid !== 1'b1 && n < 8000) begin
			@(negedge i_clk_sys);
			n++;
		end
		check("answer pulse", {23'h0, o_rsp_valid}, 24'h000001);
	endtask

	task automatic wait_cal();
		int n;
		n = 0;
		while (o_cal_done !== 1'b1 && n < 60000) begin
			@(negedge i_clk_sys);
			n++;
		end
		check("cal done", {23'h0, o_cal_done}, 24'h000001);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_init();
		wait_cal();
		check("spi strap", {23'h0, o_protocol_select_pin}, 24'h0);
		for (int i = 0; i < 8; i++) begin
			i_cal_idx = i[2:0];
			repeat (2) @(negedge i_clk_sys);
			check("cal word", {8'h0, o_cal_word}, {8'h0, exp_prom(i[2:0])});
		end
		$display("test init done");
	endtask

	task automatic t_stale_and_prom();
		run_cmd(8'h00);
		check("no conversion", o_rsp.data, 24'h0);
		run_cmd(8'hA6);
		check("prom word", o_rsp.data, {8'h0, exp_prom(3'h3)});
		run_cmd(8'h1E);
		check("reset ack", {23'h0, o_rsp.err}, 24'h0);
		$display("test stale and prom done");
	endtask

	task automatic t_conversions();
		logic [7:0] c;
		for (int i = 0; i < 10; i++) begin
			c = (i < 5) ? 8'h40 : 8'h50;
			c = c + 8'(2 * (i % 5));
			run_cmd(c);
			run_cmd(8'h00);
			check("result", o_rsp.data, (i < 5) ? PRES : TEMP);
		end
		run_cmd(8'h00);
		check("second read", o_rsp.data, 24'h0);
		$display("test conversions done");
	endtask

	task automatic t_two_wire();
		do_reset(1'b1);
		starts = 0;
		stops  = 0;
		nbit   = 0;
		wait_cal();
		check("i2c strap", {23'h0, o_protocol_select_pin}, 24'h1);
		check("csb level", {23'h0, o_select_pin_n}, 24'h1);
		check("address", {16'h0, addr}, 24'h0000EC);
		run_cmd(8'h00);
		check("no ack", {23'h0, o_rsp.err}, 24'h000001);
		repeat (200) @(negedge i_clk_sys);
		check("stops", 24'(stops), 24'(starts));
		$display("test two wire done");
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard, a little above the expected run of about 86000 cycles
	initial begin
		#2400000;
		failures++;
		end_sim();
	end

	initial begin
		do_reset(1'b0);
		t_init();
		t_stale_and_prom();
		t_conversions();
		t_two_wire();
		end_sim();
	end
endmodule
